// ==== src/dcs_charge_seq.sv ====
// dual-connector charge sequencer with avalon-mm register slave
// Summary of operation
// - operator mode picks one-connector or two-connector sequence
// - dual mode waits until both connectors plugged
// - second connector init after first plus delay
// - stagger delay register has configurable default
// - each cable check request gets a response
// - second insulation check after first plus delay
// - every shared step offset by stagger delay
// - pre-charge tracks voltage, clamps current to 2 A
// - current demand in transfer answered with limits, present values, status
// - contactors open only below 1 A
// - alarm stop on one connector stops other in dual mode
// - in separate mode, outputs never disturb each other
// - separate positive and negative contactor per connector
// - separate vehicles run independent unstaggered sequences
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module dcs_charge_seq #(
  parameter logic [31:0] STAGGER_DEFAULT = dcs_pkg::DCS_STAGGER_CYC
) (
  input  wire logic                       ref_clk,
  input  wire logic                       arst_n,
  input  wire logic [dcs_pkg::DCS_AW-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  dcs_pkg::dcs_ev_in_s             ev_in  [2],
  output dcs_pkg::dcs_ev_out_s            ev_out [2]
);
  import dcs_pkg::*;

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic active(input dcs_state_e s);
    return (s == ST_INIT) || (s == ST_CABLE) || (s == ST_PRECHG) || (s == ST_XFER);
  endfunction

  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // register slave: one wait cycle, then the request completes
  logic        bus_ack;
  logic [31:0] ctrl;
  logic [31:0] stagger;
  logic [31:0] limit;
  logic [31:0] status;
  wire         bus_req  = avs_read | avs_write;
  wire         wr_fire  = avs_write & bus_ack;
  wire         rd_load  = avs_read & ~bus_ack;
  wire         sel_ctrl = avs_address == DCS_ADDR_CTRL;
  wire         sel_stg  = avs_address == DCS_ADDR_STAGGER;
  wire         sel_stat = avs_address == DCS_ADDR_STATUS;
  wire         sel_lim  = avs_address == DCS_ADDR_LIMIT;
  wire  [31:0] rd_mux   = sel_ctrl ? ctrl : sel_stg ? stagger : sel_stat ? status : sel_lim ? limit : 32'h00000000;
  wire  [31:0] ctrl_new = merge_be(ctrl, avs_writedata, avs_byteenable);

  assign avs_waitrequest = bus_req & ~bus_ack;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack      <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (rd_load) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= DCS_CTRL_RST;
      stagger <= STAGGER_DEFAULT;
      limit   <= DCS_LIMIT_RST;
    end else if (wr_fire) begin
      if (sel_ctrl) begin
        ctrl <= {30'h0000000, ctrl_new[1:0]};
      end
      if (sel_stg) begin
        stagger <= merge_be(stagger, avs_writedata, avs_byteenable);
      end
      if (sel_lim) begin
        limit <= merge_be(limit, avs_writedata, avs_byteenable);
      end
    end
  end

  // mode is read at every step, not only when a session starts; changing it mid-session is not guarded
  wire dcs_mode_e   mode  = dcs_mode_e'(ctrl[DCS_CTRL_MODE_LSB +: 2]);
  wire              dual  = mode == DCS_DUAL;
  wire logic [15:0] i_max = limit[DCS_LIMIT_I_LSB +: 16];
  wire logic [15:0] v_max = limit[DCS_LIMIT_V_LSB +: 16];

  dcs_state_e st      [2];
  dcs_state_e next_st [2];
  logic       step_ok [2];
  logic       start_ok[2];
  logic       halt    [2];
  logic       done_ev [2];
  logic       done_q  [2];
  logic       cont    [2];

  // stagger release: second connector may follow the first one step behind
  logic [31:0] cnt;
  dcs_state_e  pend;
  dcs_state_e  rel;
  logic        abort;
  wire         a_load  = dual && (next_st[0] != st[0]) && active(next_st[0]);
  wire         a_idle  = next_st[0] == ST_IDLE;
  wire         both_idle = (st[0] == ST_IDLE) && (st[1] == ST_IDLE);
  wire         abort_set = dual && ((ev_in[0].stop_req && ev_in[0].alarm && active(st[0])) ||
                                    (ev_in[1].stop_req && ev_in[1].alarm && active(st[1])));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 32'h00000000;
      pend <= ST_IDLE;
      rel  <= ST_IDLE;
    end else if (a_idle) begin
      cnt  <= 32'h00000000;
      pend <= ST_IDLE;
      rel  <= ST_IDLE;
    end else if (a_load) begin
      cnt  <= stagger;
      pend <= next_st[0];
    end else if (cnt != 32'h00000000) begin
      cnt <= cnt - 32'h00000001;
    end else begin
      rel <= pend;
    end
  end

  // set beats clear; a held abort clears only once both connectors sit idle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort <= 1'b0;
    end else begin
      abort <= abort_set | (abort & ~both_idle);
    end
  end

  assign status = {13'h0000, rel, 2'b00, abort, cnt != 32'h00000000, 2'b00, cont[1], cont[0],
                   1'b0, st[1], 1'b0, st[0]};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gun
      logic        cc_res;
      logic        cd_res;
      logic [15:0] i_set;
      logic [15:0] v_set;
      logic [15:0] i_pres;
      logic [15:0] v_pres;
      wire  [3:0]  tgt   = {1'b0, st[g]} + 4'h1;
      wire         rel_ok = (tgt == {1'b0, ST_XFER}) ? (rel >= ST_XFER) : ({1'b0, rel} > tgt);
      wire         cc_now = (st[g] == ST_CABLE) && ev_in[g].cc_req;
      wire         cd_now = (st[g] == ST_XFER) && ev_in[g].cd_req;

      assign step_ok[g]  = (g == 0) || !dual || rel_ok;
      assign start_ok[g] = (mode == DCS_SEPARATE) ? ev_in[g].plugged :
                           dual ? (ev_in[0].plugged && ev_in[1].plugged && !abort) :
                           (mode == DCS_SINGLE) ? ((g == 0) && ev_in[0].plugged) : 1'b0;
      assign halt[g]     = ev_in[g].stop_req || (dual && (abort || abort_set));
      assign done_ev[g]  = (st[g] == ST_INIT)   ? ev_in[g].init_done :
                           (st[g] == ST_CABLE)  ? ev_in[g].cc_req :
                           (st[g] == ST_PRECHG) ? ev_in[g].cd_req : 1'b0;

      always_comb begin
        next_st[g] = st[g];
        unique case (st[g])
          ST_IDLE: begin
            if (start_ok[g] && step_ok[g]) begin
              next_st[g] = ST_INIT;
            end
          end
          ST_INIT, ST_CABLE, ST_PRECHG: begin
            if (halt[g]) begin
              next_st[g] = ST_STOP;
            end else if ((done_ev[g] || done_q[g]) && step_ok[g]) begin
              next_st[g] = dcs_state_e'(tgt[2:0]);
            end
          end
          ST_XFER: begin
            if (halt[g]) begin
              next_st[g] = ST_STOP;
            end
          end
          ST_STOP: begin
            if (ev_in[g].i_meas < DCS_OPEN_THR_DA) begin
              next_st[g] = ST_OPEN;
            end
          end
          ST_OPEN: begin
            if (!ev_in[g].plugged) begin
              next_st[g] = ST_IDLE;
            end
          end
          default: begin
            next_st[g] = ST_IDLE;
          end
        endcase
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          st[g]     <= ST_IDLE;
          done_q[g] <= 1'b0;
          cont[g]   <= 1'b0;
          cc_res    <= 1'b0;
          cd_res    <= 1'b0;
        end else begin
          st[g]     <= next_st[g];
          done_q[g] <= (next_st[g] == st[g]) && (done_q[g] || done_ev[g]);
          cont[g]   <= (next_st[g] == ST_PRECHG) || (next_st[g] == ST_XFER) || (next_st[g] == ST_STOP);
          cc_res    <= cc_now;
          cd_res    <= cd_now;
        end
      end

      // setpoints; zero current outside pre-charge and transfer
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          i_set  <= 16'h0000;
          v_set  <= 16'h0000;
          i_pres <= 16'h0000;
          v_pres <= 16'h0000;
        end else begin
          if ((st[g] == ST_PRECHG) && ev_in[g].pc_req) begin
            i_set <= min16(ev_in[g].i_req, DCS_PC_CEIL_DA);
            v_set <= min16(ev_in[g].v_req, v_max);
          end else if (cd_now) begin
            i_set <= min16(ev_in[g].i_req, i_max);
            v_set <= min16(ev_in[g].v_req, v_max);
          end else if ((st[g] != ST_PRECHG) && (st[g] != ST_XFER)) begin
            i_set <= 16'h0000;
          end
          if (cd_now) begin
            i_pres <= ev_in[g].i_meas;
            v_pres <= ev_in[g].v_meas;
          end
        end
      end

      assign ev_out[g] = '{init_en: (st[g] == ST_INIT), cc_res: cc_res, cd_res: cd_res,
                           cont_pos: cont[g], cont_neg: cont[g], status: st[g],
                           i_set: i_set, v_set: v_set, i_lim: i_max, v_lim: v_max,
                           i_pres: i_pres, v_pres: v_pres};

      property p_pc_clamp;
        @(posedge ref_clk) disable iff (!rst_n)
        (st[g] == ST_PRECHG) |-> (ev_out[g].i_set <= DCS_PC_CEIL_DA);
      endproperty
      a_pc_clamp: assert property (p_pc_clamp) else $error("pre-charge current above ceiling");

      property p_open_low;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(ev_out[g].cont_pos) |-> ($past(ev_in[g].i_meas) < DCS_OPEN_THR_DA);
      endproperty
      a_open_low: assert property (p_open_low) else $error("contactor opened at high current");

      property p_pos_neg;
        @(posedge ref_clk) disable iff (!rst_n)
        (ev_out[g].cont_pos == ev_out[g].cont_neg) && (ev_out[g].cont_pos == (st[g] inside {ST_PRECHG, ST_XFER, ST_STOP}));
      endproperty
      a_pos_neg: assert property (p_pos_neg) else $error("line contactors disagree");

      property p_cc_res;
        @(posedge ref_clk) disable iff (!rst_n)
        (st[g] == ST_CABLE && ev_in[g].cc_req) |=> ev_out[g].cc_res ##1 !ev_out[g].cc_res || ev_in[g].cc_req;
      endproperty
      a_cc_res: assert property (p_cc_res) else $error("cable check not answered");

      property p_cd_res;
        @(posedge ref_clk) disable iff (!rst_n)
        (st[g] == ST_XFER && ev_in[g].cd_req) |=> ev_out[g].cd_res && (ev_out[g].i_pres == $past(ev_in[g].i_meas));
      endproperty
      a_cd_res: assert property (p_cd_res) else $error("current demand not answered");
    end
  endgenerate

  default clocking dcs_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_dual_plugged;
    (dual && st[0] == ST_IDLE && st[1] == ST_IDLE ##1 st[0] == ST_INIT) |->
      ($past(ev_in[0].plugged) && $past(ev_in[1].plugged));
  endproperty
  a_dual_plugged: assert property (p_dual_plugged) else $error("dual start without both plugged");

  property p_b_after_a;
    (dual && $past(st[1]) == ST_INIT && st[1] == ST_CABLE) |-> ($past(rel) > ST_CABLE);
  endproperty
  a_b_after_a: assert property (p_b_after_a) else $error("second check before stagger");

  property p_stagger_load;
    a_load |=> (cnt == $past(stagger)) ##1 (cnt == $past(stagger, 2) - 32'h00000001 ||
                                            $past(stagger, 2) == 32'h00000000 || $past(a_load) || $past(a_idle));
  endproperty
  a_stagger_load: assert property (p_stagger_load) else $error("stagger not loaded");

  property p_b_init_gate;
    (dual && st[1] == ST_IDLE ##1 st[1] == ST_INIT) |-> ($past(rel) > ST_INIT);
  endproperty
  a_b_init_gate: assert property (p_b_init_gate) else $error("second init before stagger");

  property p_cross;
    (dual && ev_in[0].stop_req && ev_in[0].alarm && active(st[0]) && active(st[1])) |=> (st[1] == ST_STOP);
  endproperty
  a_cross: assert property (p_cross) else $error("alarm stop not mirrored");

  property p_single;
    (mode == DCS_SINGLE && st[1] == ST_IDLE) |=> (st[1] == ST_IDLE);
  endproperty
  a_single: assert property (p_single) else $error("second connector ran in single mode");

  property p_separate;
    (mode == DCS_SEPARATE && st[1] == ST_IDLE && ev_in[1].plugged) |=> (st[1] == ST_INIT);
  endproperty
  a_separate: assert property (p_separate) else $error("separate connector was held");

  property p_isolated;
    (mode == DCS_SEPARATE && st[1] == ST_XFER && !ev_in[1].stop_req) |=> (st[1] == ST_XFER);
  endproperty
  a_isolated: assert property (p_isolated) else $error("connector disturbed by other");

  c_dual_xfer: cover property (dual && st[0] == ST_XFER && st[1] == ST_XFER);
  c_cross_stop: cover property (abort_set && st[1] == ST_XFER);
  c_sep_xfer: cover property (mode == DCS_SEPARATE && st[0] == ST_XFER && st[1] == ST_XFER);
  c_stagger_run: cover property (a_load ##1 cnt != 32'h00000000 ##[1:20] rel == ST_CABLE);

endmodule

// ==== src/dcs_pkg.sv ====
// constants, types and register map of the dual-connector charge sequencer
package dcs_pkg;

  localparam int          DCS_CLK_HZ     = 40000000;
  localparam int          DCS_STAGGER_MS = 1000;
  localparam logic [31:0] DCS_STAGGER_CYC = 32'(longint'(DCS_STAGGER_MS) * longint'(DCS_CLK_HZ / 1000));

  // currents in units of 0.1 A
  localparam logic [15:0] DCS_PC_CEIL_DA  = 16'h0014;
  localparam logic [15:0] DCS_OPEN_THR_DA = 16'h000a;

  localparam int          DCS_AW          = 4;
  localparam logic [3:0]  DCS_ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  DCS_ADDR_STAGGER = 4'h4;
  localparam logic [3:0]  DCS_ADDR_STATUS  = 4'h8;
  localparam logic [3:0]  DCS_ADDR_LIMIT   = 4'hc;

  localparam logic [31:0] DCS_CTRL_RST  = 32'h00000003;
  localparam logic [31:0] DCS_LIMIT_RST = 32'h271003e8;

  localparam int DCS_CTRL_MODE_LSB   = 0;
  localparam int DCS_LIMIT_I_LSB     = 0;
  localparam int DCS_LIMIT_V_LSB     = 16;
  localparam int DCS_STAT_ST0_LSB    = 0;
  localparam int DCS_STAT_ST1_LSB    = 4;
  localparam int DCS_STAT_CONT0_BIT  = 8;
  localparam int DCS_STAT_CONT1_BIT  = 9;
  localparam int DCS_STAT_BUSY_BIT   = 12;
  localparam int DCS_STAT_ABORT_BIT  = 13;
  localparam int DCS_STAT_REL_LSB    = 16;

  typedef enum logic [1:0] {
    DCS_SINGLE   = 2'b00,
    DCS_DUAL     = 2'b01,
    DCS_SEPARATE = 2'b10,
    DCS_OFF      = 2'b11
  } dcs_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_INIT   = 3'b001,
    ST_CABLE  = 3'b010,
    ST_PRECHG = 3'b011,
    ST_XFER   = 3'b100,
    ST_STOP   = 3'b101,
    ST_OPEN   = 3'b110
  } dcs_state_e;

  typedef struct packed {
    logic        plugged;
    logic        init_done;
    logic        cc_req;
    logic        pc_req;
    logic        cd_req;
    logic        stop_req;
    logic        alarm;
    logic [15:0] i_req;
    logic [15:0] v_req;
    logic [15:0] i_meas;
    logic [15:0] v_meas;
  } dcs_ev_in_s;

  typedef struct packed {
    logic        init_en;
    logic        cc_res;
    logic        cd_res;
    logic        cont_pos;
    logic        cont_neg;
    logic [2:0]  status;
    logic [15:0] i_set;
    logic [15:0] v_set;
    logic [15:0] i_lim;
    logic [15:0] v_lim;
    logic [15:0] i_pres;
    logic [15:0] v_pres;
  } dcs_ev_out_s;

endpackage

// ==== testbench/dcs_vehicle_model.sv ====
// vehicle-side charging controller model for one connector
`timescale 1ns/1ps
module dcs_vehicle_model (
  input  wire logic            ref_clk,
  input  wire logic            plug,
  input  wire logic            stop,
  input  wire logic            alarm,
  input  wire logic            slow,
  input  wire logic [15:0]     rnd_i,
  input  wire logic [15:0]     rnd_v,
  input  dcs_pkg::dcs_ev_out_s ev_out,
  output dcs_pkg::dcs_ev_in_s  ev_in
);
  import dcs_pkg::*;
  logic [2:0] last_st = 3'h0;
  logic [7:0] cnt     = 8'h00;
  wire  [7:0] dly     = slow ? 8'h09 : 8'h01;
  wire  [2:0] st      = ev_out.status;
  // count is stale on the first cycle of a new state, so never fire there
  wire        same    = (st == last_st);
  wire        fire    = same && (cnt == dly);
  wire        xfer_ev = same && (st == ST_XFER) && (cnt[3:0] == 4'h5);
  initial ev_in = '0;
  // init, cable and pre-charge steps answered after a short or long think time
  always @(posedge ref_clk) begin
    cnt             <= (st != last_st) ? 8'h00 : cnt + 8'h01;
    last_st         <= st;
    ev_in.init_done <= (st == ST_INIT) && fire;
    ev_in.cc_req    <= (st == ST_CABLE) && fire;
    ev_in.pc_req    <= (st == ST_PRECHG) && fire;
    // demands stop once transfer ends: pilot back to B, vehicle not ready
    ev_in.cd_req    <= ((st == ST_PRECHG) && same && (cnt == dly + 8'h04)) || xfer_ev;
    ev_in.stop_req  <= stop;
    ev_in.alarm     <= alarm;
    if (((st == ST_PRECHG) && fire) || xfer_ev) begin
      ev_in.i_req <= rnd_i;
      ev_in.v_req <= rnd_v;
    end
    // slow plant keeps current up for a while after the setpoint drops
    ev_in.i_meas  <= !ev_out.cont_pos ? ev_in.i_meas >> 1 :
                     slow ? (ev_in.i_meas >> 1) + (ev_out.i_set >> 1) : ev_out.i_set;
    ev_in.v_meas  <= ev_out.cont_pos ? ev_out.v_set : ev_in.v_meas >> 1;
    // optional weld check skipped; lock held while output stays high
    ev_in.plugged <= plug || (ev_in.plugged && (ev_in.v_meas >= 16'h0258));
  end
endmodule

// ==== testbench/test_dcs_charge_seq.sv ====
// self-checking bench for the dual-connector charge sequencer
`timescale 1ns/1ps
module test_dcs_charge_seq;
  import dcs_pkg::*;
  localparam logic [31:0] STG_RST = 32'h00000008;
  localparam int          STG     = 6;
  logic              ref_clk        = 1'b0;
  logic              arst_n         = 1'b0;
  logic [DCS_AW-1:0] avs_address    = '0;
  logic              avs_read       = 1'b0;
  logic              avs_write      = 1'b0;
  logic [31:0]       avs_writedata  = '0;
  logic [3:0]        avs_byteenable = '0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  dcs_ev_in_s        ev_in [2];
  dcs_ev_out_s       ev_out [2];
  logic [1:0]        plug = '0, stop = '0, alarm = '0, slow = '0;
  logic [31:0]       rnd = 32'h8a4ab322;
  logic [31:0]       rd;
  logic [15:0]       lim_i = 16'h03e8, lim_v = 16'h2710;
  int                bad_count = 0, cmp_count = 0, cyc = 0;
  int                t_ent [2][8];
  logic [2:0]        pst [2] = '{3'h0, 3'h0};
  logic [1:0]        pcc, pcd, ppc, pcont;
  logic [15:0]       pim [2], piq [2], pvq [2], pvm [2];

  initial begin
    forever begin
      #12.5;
      ref_clk = ~ref_clk;
    end
  end

  dcs_charge_seq #(.STAGGER_DEFAULT(STG_RST)) u_dcs_charge_seq (
    .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ev_in(ev_in), .ev_out(ev_out));

  for (genvar g = 0; g < 2; g++) begin : gen_veh
    dcs_vehicle_model u_dcs_vehicle_model (.ref_clk(ref_clk), .plug(plug[g]), .stop(stop[g]),
      .alarm(alarm[g]), .slow(slow[g]), .rnd_i(rnd[15:0] ^ 16'(g)), .rnd_v(rnd[31:16]),
      .ev_out(ev_out[g]), .ev_in(ev_in[g]));
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h00400007 : 32'h00000000);
  endfunction

  function automatic logic [15:0] f_lim(input logic [15:0] v, input logic [15:0] m);
    return (v > m) ? m : v;
  endfunction

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_t(input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: relation does not hold", $time);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk_t(1'b0);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h0);
    chk_w({16'h0000, rd & m}, {16'h0000, e});
  endtask

  task automatic wait_st(input int g, input logic [2:0] st, input int lim);
    int n;
    n = 0;
    while (ev_out[g].status !== st && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk_t(n < lim);
  endtask

  task automatic go(input logic [1:0] m, input logic [1:0] pl);
    bus(1'b1, DCS_ADDR_CTRL, {30'h0, m}, 4'hf);
    t_ent = '{default: 0};
    plug <= pl;
  endtask

  task automatic halt(input int g, input logic al);
    @(posedge ref_clk);
    stop[g]  <= 1'b1;
    alarm[g] <= al;
    @(posedge ref_clk);
    stop[g]  <= 1'b0;
  endtask

  task automatic done(input int g);
    wait_st(g, ST_OPEN, 400);
    plug[g]  <= 1'b0;
    alarm[g] <= 1'b0;
    wait_st(g, ST_IDLE, 400);
  endtask

  always @(posedge ref_clk) begin
    rnd <= lfsr(rnd);
    cyc++;
    for (int g = 0; g < 2; g++) begin
      if (arst_n) begin
        if (ev_out[g].status !== pst[g]) t_ent[g][ev_out[g].status] = cyc;
        pst[g] = ev_out[g].status;
        chk_t(ev_out[g].cont_pos === ev_out[g].cont_neg);
        chk_t(ev_out[g].init_en === (ev_out[g].status == ST_INIT));
        if (ev_out[g].cc_res) chk_t(pcc[g]);
        if (ppc[g]) begin
          chk_w({16'h0000, ev_out[g].v_set, ev_out[g].i_set},
                {16'h0000, f_lim(pvq[g], lim_v), f_lim(piq[g], DCS_PC_CEIL_DA)});
        end
        if (ev_out[g].cd_res) chk_w({ev_out[g].v_lim, ev_out[g].i_lim, ev_out[g].i_pres}, {lim_v, lim_i, pim[g]});
        if (ev_out[g].cd_res) begin
          chk_w({16'h0000, ev_out[g].v_set, ev_out[g].i_set},
                {16'h0000, f_lim(pvq[g], lim_v), f_lim(piq[g], lim_i)});
          chk_w({32'h00000000, ev_out[g].v_pres}, {32'h00000000, pvm[g]});
        end
        if (ev_out[g].cd_res) chk_t(pcd[g]);
        if (pcont[g] && !ev_out[g].cont_pos) chk_t(pim[g] < DCS_OPEN_THR_DA);
      end
      pcc[g]   = ev_in[g].cc_req;
      pcd[g]   = ev_in[g].cd_req;
      ppc[g]   = ev_in[g].pc_req;
      piq[g]   = ev_in[g].i_req;
      pvq[g]   = ev_in[g].v_req;
      pvm[g]   = ev_in[g].v_meas;
      pim[g]   = ev_in[g].i_meas;
      pcont[g] = ev_out[g].cont_pos;
    end
  end

  // a full run takes a few hundred cycles
  initial begin
    #500000;
    bad_count++;
    wrap_up;
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rdchk(DCS_ADDR_CTRL, 32'hffffffff, DCS_CTRL_RST);
    rdchk(DCS_ADDR_STAGGER, 32'hffffffff, STG_RST);
    rdchk(DCS_ADDR_LIMIT, 32'hffffffff, DCS_LIMIT_RST);
    rdchk(DCS_ADDR_STATUS, 32'h000003ff, 32'h0);
    bus(1'b1, 4'h2, rnd, 4'hf);
    rdchk(4'h2, 32'hffffffff, 32'h0);
    rdchk(DCS_ADDR_CTRL, 32'hffffffff, DCS_CTRL_RST);
    lim_i = 16'h0100 | {8'h00, rnd[7:0]};
    bus(1'b1, DCS_ADDR_LIMIT, {rnd[31:16], lim_i}, 4'h3);
    rdchk(DCS_ADDR_LIMIT, 32'hffffffff, {lim_v, lim_i});
    bus(1'b1, DCS_ADDR_STAGGER, 32'(STG), 4'hf);
    rdchk(DCS_ADDR_STAGGER, 32'hffffffff, 32'(STG));
    go(DCS_OFF, 2'b11);
    repeat (40) @(posedge ref_clk);
    chk_t(t_ent[0][ST_INIT] == 0 && t_ent[1][ST_INIT] == 0);
    plug <= 2'b00;
    repeat (5) @(posedge ref_clk);
    slow <= 2'b01;
    go(DCS_SINGLE, 2'b11);
    wait_st(0, ST_XFER, 400);
    repeat (50) @(posedge ref_clk);
    chk_t(t_ent[1][ST_INIT] == 0);
    halt(0, 1'b0);
    done(0);
    plug <= 2'b00;
    wait_st(1, ST_IDLE, 10);
    slow <= 2'b11;
    go(DCS_DUAL, 2'b01);
    repeat (40) @(posedge ref_clk);
    chk_t(t_ent[0][ST_INIT] == 0);
    plug <= 2'b11;
    wait_st(1, ST_XFER, 600);
    // let the monitor log the entry time first
    @(posedge ref_clk);
    chk_t((t_ent[1][ST_INIT] - t_ent[0][ST_CABLE]) inside {[STG:STG+4]});
    for (int s = 2; s < 5; s++) chk_t(t_ent[1][s] - t_ent[0][s] >= STG);
    rdchk(DCS_ADDR_STATUS, 32'h000003ff, 32'h00000344);
    halt(1, 1'b1);
    wait_st(0, ST_STOP, 8);
    done(0);
    done(1);
    slow <= 2'b00;
    go(DCS_SEPARATE, 2'b11);
    wait_st(0, ST_XFER, 400);
    wait_st(1, ST_XFER, 10);
    chk_t(t_ent[0][ST_INIT] == t_ent[1][ST_INIT]);
    halt(0, 1'b1);
    done(0);
    chk_t(ev_out[1].status === ST_XFER);
    halt(1, 1'b0);
    done(1);
    wrap_up;
  end
endmodule
